// File: dpicf_regs.sv
// Digital PLL input and feedback configuration register bank, byte-wide register port
`timescale 1ns/1ps
`default_nettype none
module dpicf_regs
	import dpicf_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	// Register port from the serial interface
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Status from the PLL datapath
	input wire logic phase_locked,
	input wire logic ref_in_use,
	// Configuration to the PLL datapath
	output logic auto_ref_select,
	output logic force_free_running,
	output logic force_normal_track,
	output logic [3:0] active_bandwidth,
	output logic [2:0] active_damping,
	output logic [1:0] loop_filter_gain,
	output logic [20:0] active_predivider,
	output logic [23:0] active_feedback_divider,
	output logic [7:0] phase_window,
	output logic [29:0] modulator_value,
	output logic [1:0] modulator_order,
	output logic [1:0] oscillator_control_gain,
	output logic [2:0] dither_gain
);
	typedef struct packed {
		logic [2:0] ref_sel;
		logic [1:0] state_ctrl;
		logic [20:0] clk_pre;
		logic [20:0] fb_pre;
		logic [23:0] clk_fbdiv;
		logic [23:0] fb_fbdiv;
		logic [3:0] lock_bw;
		logic [3:0] acq_bw;
		logic [2:0] lock_damp;
		logic [2:0] acq_damp;
		logic [1:0] gain;
		logic quick_acq;
		logic [7:0] phase_win;
		logic [8:0] mod_int;
		logic [20:0] mod_frac;
		logic [1:0] mod_order;
		logic [1:0] osc_gain;
		logic [2:0] dither;
		logic [7:0] rdata;
		logic rvalid;
		logic auto_ref;
		logic force_free;
		logic force_norm;
		logic [3:0] act_bw;
		logic [2:0] act_damp;
		logic [20:0] act_pre;
		logic [23:0] act_fbdiv;
		logic [29:0] mod_value;
	} dpicf_state_s;

	// Reset image; derived outputs match the reset fields
	localparam dpicf_state_s RESET_STATE = '{
		ref_sel: RST_REF_SEL, state_ctrl: RST_STATE_CTRL,
		clk_pre: RST_PREDIV, fb_pre: RST_PREDIV,
		clk_fbdiv: RST_FBDIV, fb_fbdiv: RST_FBDIV,
		lock_bw: RST_LOCK_BW, acq_bw: RST_ACQ_BW,
		lock_damp: RST_LOCK_DAMP, acq_damp: RST_ACQ_DAMP,
		gain: RST_GAIN, quick_acq: RST_QUICK_ACQ, phase_win: RST_PHASE_WIN,
		mod_int: RST_MOD_INT, mod_frac: RST_MOD_FRAC,
		mod_order: RST_MOD_ORDER, osc_gain: RST_OSC_GAIN, dither: RST_DITHER,
		rdata: UNMAPPED_BYTE, rvalid: 1'b0,
		auto_ref: 1'b1, force_free: 1'b0, force_norm: 1'b0,
		act_bw: RST_ACQ_BW, act_damp: RST_ACQ_DAMP,
		act_pre: RST_PREDIV, act_fbdiv: RST_FBDIV,
		mod_value: {RST_MOD_INT, RST_MOD_FRAC}
	};

	dpicf_state_s st_reg;
	dpicf_state_s st_next;
	dpicf_sel_if sif ();

	// Selector works on the next field values so outputs settle with the fields
	dpicf_loop_sel u_sel (
		.sif(sif.sel)
	);

	// Feed the selector
	assign sif.quick_acquire_enable = st_next.quick_acq;
	assign sif.phase_locked = phase_locked;
	assign sif.ref_in_use = ref_in_use;
	assign sif.state_ctrl = st_next.state_ctrl;
	assign sif.locked_bandwidth = st_next.lock_bw;
	assign sif.acquire_bandwidth = st_next.acq_bw;
	assign sif.locked_damping = st_next.lock_damp;
	assign sif.acquire_damping = st_next.acq_damp;
	assign sif.clk_ref_predivider = st_next.clk_pre;
	assign sif.fb_ref_predivider = st_next.fb_pre;
	assign sif.clk_ref_feedback_divider = st_next.clk_fbdiv;
	assign sif.fb_ref_feedback_divider = st_next.fb_fbdiv;

	// Next state: writes, read data, derived outputs
	always_comb begin
		logic [23:0] t;
		logic [7:0] rd;
		t = 24'h000000;
		rd = UNMAPPED_BYTE;
		st_next = st_reg;
		// Writes land byte by byte; reserved bit positions are simply not stored
		if (reg_wr) begin
			if (reg_addr == OFS_REF_SELECT) begin
				st_next.ref_sel = reg_wdata[REF_SEL_LSB +: 3];
			end
			if (reg_addr == OFS_PLL_STATE) begin
				st_next.state_ctrl = reg_wdata[1:0];
			end
			if (dpicf_hit3(reg_addr, OFS_CLK_PREDIV)) begin
				t = dpicf_put({3'h0, st_reg.clk_pre}, dpicf_idx(reg_addr, OFS_CLK_PREDIV), reg_wdata);
				st_next.clk_pre = t[20:0];
			end
			if (dpicf_hit3(reg_addr, OFS_FB_PREDIV)) begin
				t = dpicf_put({3'h0, st_reg.fb_pre}, dpicf_idx(reg_addr, OFS_FB_PREDIV), reg_wdata);
				st_next.fb_pre = t[20:0];
			end
			if (dpicf_hit3(reg_addr, OFS_CLK_FBDIV)) begin
				st_next.clk_fbdiv = dpicf_put(st_reg.clk_fbdiv, dpicf_idx(reg_addr, OFS_CLK_FBDIV), reg_wdata);
			end
			if (dpicf_hit3(reg_addr, OFS_FB_FBDIV)) begin
				st_next.fb_fbdiv = dpicf_put(st_reg.fb_fbdiv, dpicf_idx(reg_addr, OFS_FB_FBDIV), reg_wdata);
			end
			if (reg_addr == OFS_LOOP_BW) begin
				st_next.lock_bw = reg_wdata[BW_LOCK_LSB +: 4];
				st_next.acq_bw = reg_wdata[BW_ACQ_LSB +: 4];
			end
			if (reg_addr == OFS_DAMP_GAIN) begin
				st_next.lock_damp = reg_wdata[DAMP_LOCK_LSB +: 3];
				st_next.acq_damp = reg_wdata[DAMP_ACQ_LSB +: 3];
				st_next.gain = reg_wdata[GAIN_LSB +: 2];
			end
			if (reg_addr == OFS_QUICK_ACQ) begin
				st_next.quick_acq = reg_wdata[0];
			end
			// Zero is stored as written; the loop must never be given it (phase_window passes it on unchanged)
			if (reg_addr == OFS_PHASE_WIN) begin
				st_next.phase_win = reg_wdata;
			end
			// Integer is split 1 + 8 bits, high part first
			if (reg_addr == OFS_MOD_INT) begin
				st_next.mod_int[8] = reg_wdata[0];
			end
			if (reg_addr == OFS_MOD_INT + 10'h001) begin
				st_next.mod_int[7:0] = reg_wdata;
			end
			if (dpicf_hit3(reg_addr, OFS_MOD_FRAC)) begin
				t = dpicf_put({3'h0, st_reg.mod_frac}, dpicf_idx(reg_addr, OFS_MOD_FRAC), reg_wdata);
				st_next.mod_frac = t[20:0];
			end
			if (reg_addr == OFS_MOD_ORDER) begin
				st_next.mod_order = reg_wdata[ORDER_LSB +: 2];
				st_next.osc_gain = reg_wdata[OSC_GAIN_LSB +: 2];
				st_next.dither = reg_wdata[DITHER_LSB +: 3];
			end
		end
		// Read mux on current contents; reserved bits read as zero
		if (reg_addr == OFS_REF_SELECT) begin
			rd = {st_reg.ref_sel, REF_FIXED_LOW};
		end else if (reg_addr == OFS_PLL_STATE) begin
			rd = {6'h00, st_reg.state_ctrl};
		end else if (dpicf_hit3(reg_addr, OFS_CLK_PREDIV)) begin
			rd = dpicf_get({3'h0, st_reg.clk_pre}, dpicf_idx(reg_addr, OFS_CLK_PREDIV));
		end else if (dpicf_hit3(reg_addr, OFS_FB_PREDIV)) begin
			rd = dpicf_get({3'h0, st_reg.fb_pre}, dpicf_idx(reg_addr, OFS_FB_PREDIV));
		end else if (dpicf_hit3(reg_addr, OFS_CLK_FBDIV)) begin
			rd = dpicf_get(st_reg.clk_fbdiv, dpicf_idx(reg_addr, OFS_CLK_FBDIV));
		end else if (dpicf_hit3(reg_addr, OFS_FB_FBDIV)) begin
			rd = dpicf_get(st_reg.fb_fbdiv, dpicf_idx(reg_addr, OFS_FB_FBDIV));
		end else if (reg_addr == OFS_LOOP_BW) begin
			rd = {st_reg.lock_bw, st_reg.acq_bw};
		end else if (reg_addr == OFS_DAMP_GAIN) begin
			rd = {st_reg.lock_damp, st_reg.acq_damp, st_reg.gain};
		end else if (reg_addr >= OFS_ONES_FIRST && reg_addr <= OFS_ONES_LAST) begin
			rd = ONES_BYTE;
		end else if (reg_addr == OFS_QUICK_ACQ) begin
			rd = {7'h00, st_reg.quick_acq};
		end else if (reg_addr == OFS_PHASE_WIN) begin
			rd = st_reg.phase_win;
		end else if (reg_addr == OFS_MOD_INT) begin
			rd = {7'h00, st_reg.mod_int[8]};
		end else if (reg_addr == OFS_MOD_INT + 10'h001) begin
			rd = st_reg.mod_int[7:0];
		end else if (dpicf_hit3(reg_addr, OFS_MOD_FRAC)) begin
			rd = dpicf_get({3'h0, st_reg.mod_frac}, dpicf_idx(reg_addr, OFS_MOD_FRAC));
		end else if (reg_addr == OFS_FIXED_ONE) begin
			rd = FIXED_ONE_BYTE;
		end else if (reg_addr == OFS_MOD_ORDER) begin
			rd = {st_reg.mod_order, st_reg.osc_gain, 1'b0, st_reg.dither};
		end
		// Read data is held until the next read
		if (reg_rd) begin
			st_next.rdata = rd;
		end
		st_next.rvalid = reg_rd;
		// Derived outputs, registered alongside the fields
		st_next.auto_ref = (st_next.ref_sel == REF_AUTO);
		st_next.force_free = sif.force_free_running;
		st_next.force_norm = sif.force_normal_track;
		st_next.act_bw = sif.active_bandwidth;
		st_next.act_damp = sif.active_damping;
		st_next.act_pre = sif.active_predivider;
		st_next.act_fbdiv = sif.active_feedback_divider;
		st_next.mod_value = {st_next.mod_int, st_next.mod_frac};
	end

	// Single state register; reset wins over the clock enable
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_reg <= RESET_STATE;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata = st_reg.rdata;
	assign reg_rvalid = st_reg.rvalid;
	assign auto_ref_select = st_reg.auto_ref;
	assign force_free_running = st_reg.force_free;
	assign force_normal_track = st_reg.force_norm;
	assign active_bandwidth = st_reg.act_bw;
	assign active_damping = st_reg.act_damp;
	assign loop_filter_gain = st_reg.gain;
	assign active_predivider = st_reg.act_pre;
	assign active_feedback_divider = st_reg.act_fbdiv;
	assign phase_window = st_reg.phase_win;
	assign modulator_value = st_reg.mod_value;
	assign modulator_order = st_reg.mod_order;
	assign oscillator_control_gain = st_reg.osc_gain;
	assign dither_gain = st_reg.dither;

	// Checks on the registered behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_reset_defaults: assert property ($fell(srst) |-> st_reg.ref_sel == RST_REF_SEL
		&& st_reg.state_ctrl == RST_STATE_CTRL && st_reg.clk_pre == RST_PREDIV && st_reg.fb_pre == RST_PREDIV
		&& st_reg.clk_fbdiv == RST_FBDIV && st_reg.fb_fbdiv == RST_FBDIV && st_reg.quick_acq
		&& st_reg.phase_win == RST_PHASE_WIN)
		else $error("fields not at reset defaults after reset");
	a_auto_ref_decode: assert property (auto_ref_select == (st_reg.ref_sel == REF_AUTO))
		else $error("automatic reference flag disagrees with select field");
	a_state_force_decode: assert property (force_free_running == (st_reg.state_ctrl == STATE_FREE_RUNNING_STATE)
		&& force_normal_track == (st_reg.state_ctrl == STATE_NORMAL))
		else $error("state override outputs disagree with state field");
	a_state_write: assert property (ce && reg_wr && reg_addr == OFS_PLL_STATE |=> st_reg.state_ctrl == $past(reg_wdata[1:0])
		##1 (!ce || force_normal_track == (st_reg.state_ctrl == STATE_NORMAL)))
		else $error("state field write not taken");
	a_loop_settings: assert property (ce |=> active_bandwidth == ((st_reg.quick_acq && !$past(phase_locked))
		? st_reg.acq_bw : st_reg.lock_bw) && active_damping == ((st_reg.quick_acq && !$past(phase_locked))
		? st_reg.acq_damp : st_reg.lock_damp))
		else $error("wrong loop bandwidth or damping selected");
	a_prediv_select: assert property (ce |=> active_predivider == ($past(ref_in_use) ? st_reg.fb_pre : st_reg.clk_pre))
		else $error("wrong pre-divider selected");
	a_fbdiv_select: assert property (ce |=> active_feedback_divider == ($past(ref_in_use) ? st_reg.fb_fbdiv : st_reg.clk_fbdiv))
		else $error("wrong feedback divider selected");
	a_msb_lowest_addr: assert property (ce && reg_wr && reg_addr == OFS_CLK_FBDIV |=> st_reg.clk_fbdiv[23:16] == $past(reg_wdata))
		else $error("lowest address did not update the top byte");
	a_modulator_join: assert property (modulator_value[29:MOD_FRAC_W] == st_reg.mod_int
		&& modulator_value[MOD_FRAC_W-1:0] == st_reg.mod_frac)
		else $error("modulator value not integer joined with fraction");
	a_reserved_zero: assert property (ce && reg_rd && reg_addr == OFS_PLL_STATE |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
		else $error("reserved bits of state byte not read as zero");
	a_freeze_on_ce: assert property (!ce |=> $stable(st_reg))
		else $error("state changed while clock enable low");
	// Single-byte fields take the written value on the next edge
	a_ref_select_write: assert property (ce && reg_wr && reg_addr == OFS_REF_SELECT
		|=> st_reg.ref_sel == $past(reg_wdata[REF_SEL_LSB +: 3]))
		else $error("reference select write not taken");
	a_quick_write: assert property (ce && reg_wr && reg_addr == OFS_QUICK_ACQ
		|=> st_reg.quick_acq == $past(reg_wdata[0]))
		else $error("quick acquire write not taken");
	a_window_write: assert property (ce && reg_wr && reg_addr == OFS_PHASE_WIN
		|=> phase_window == $past(reg_wdata))
		else $error("phase window write not taken");
	// Byte order of multi-byte fields: top bits at the group base, low byte at its end
	a_clk_prediv_top: assert property (ce && reg_wr && reg_addr == OFS_CLK_PREDIV
		|=> st_reg.clk_pre[20:16] == $past(reg_wdata[4:0]))
		else $error("clock pre-divider top bits not at group base");
	a_fb_prediv_top: assert property (ce && reg_wr && reg_addr == OFS_FB_PREDIV
		|=> st_reg.fb_pre[20:16] == $past(reg_wdata[4:0]))
		else $error("feedback pre-divider top bits not at group base");
	a_frac_low_byte: assert property (ce && reg_wr && reg_addr == OFS_MOD_FRAC + 10'h002
		|=> st_reg.mod_frac[7:0] == $past(reg_wdata))
		else $error("fraction low byte not at group end");
	// Answer valid is a one-cycle echo of a taken read strobe
	a_read_strobe_pulse: assert property (ce |=> reg_rvalid == $past(reg_rd))
		else $error("read answer valid does not follow the read strobe");

	c_read_back: cover property (ce && reg_rd ##1 reg_rvalid);
	c_force_free: cover property (force_free_running);
	c_force_normal: cover property (force_normal_track);
	c_quick_to_locked: cover property (st_reg.quick_acq && active_bandwidth == st_reg.acq_bw ##[1:20] phase_locked);
	c_feedback_ref: cover property (ce && ref_in_use ##1 active_predivider == st_reg.fb_pre);
endmodule
`default_nettype wire

// File: dpicf_pkg.sv
// Package: offsets, field layout, reset values and helpers of the digital PLL input/feedback configuration bank
package dpicf_pkg;
	typedef logic [9:0] dpicf_addr_t;

	// Byte offsets on the serial register port
	localparam dpicf_addr_t OFS_REF_SELECT = 10'h008;
	localparam dpicf_addr_t OFS_PLL_STATE = 10'h00A;
	localparam dpicf_addr_t OFS_CLK_PREDIV = 10'h00B;
	localparam dpicf_addr_t OFS_FB_PREDIV = 10'h00E;
	localparam dpicf_addr_t OFS_CLK_FBDIV = 10'h011;
	localparam dpicf_addr_t OFS_FB_FBDIV = 10'h014;
	localparam dpicf_addr_t OFS_LOOP_BW = 10'h017;
	localparam dpicf_addr_t OFS_DAMP_GAIN = 10'h018;
	localparam dpicf_addr_t OFS_ONES_FIRST = 10'h01F;
	localparam dpicf_addr_t OFS_ONES_LAST = 10'h022;
	localparam dpicf_addr_t OFS_QUICK_ACQ = 10'h023;
	localparam dpicf_addr_t OFS_PHASE_WIN = 10'h024;
	localparam dpicf_addr_t OFS_MOD_INT = 10'h025;
	localparam dpicf_addr_t OFS_MOD_FRAC = 10'h028;
	localparam dpicf_addr_t OFS_FIXED_ONE = 10'h02C;
	localparam dpicf_addr_t OFS_MOD_ORDER = 10'h02F;

	// Field positions inside their bytes
	localparam int REF_SEL_LSB = 5;
	localparam int BW_LOCK_LSB = 4;
	localparam int BW_ACQ_LSB = 0;
	localparam int DAMP_LOCK_LSB = 5;
	localparam int DAMP_ACQ_LSB = 2;
	localparam int GAIN_LSB = 0;
	localparam int ORDER_LSB = 6;
	localparam int OSC_GAIN_LSB = 4;
	localparam int DITHER_LSB = 0;
	localparam int MOD_FRAC_W = 21;
	localparam int MOD_INT_W = 9;

	// Constant read-back patterns of fixed bytes and bits
	localparam logic [4:0] REF_FIXED_LOW = 5'h17;
	localparam logic [7:0] ONES_BYTE = 8'hFF;
	localparam logic [7:0] FIXED_ONE_BYTE = 8'h01;
	localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

	// Field codes
	localparam logic [2:0] REF_AUTO = 3'h0;
	localparam logic [1:0] STATE_AUTO = 2'h0;
	localparam logic [1:0] STATE_FREE_RUNNING_STATE = 2'h1;
	localparam logic [1:0] STATE_NORMAL = 2'h2;

	// Reset values
	localparam logic [2:0] RST_REF_SEL = 3'h0;
	localparam logic [1:0] RST_STATE_CTRL = 2'h0;
	localparam logic [20:0] RST_PREDIV = 21'h000014;
	localparam logic [23:0] RST_FBDIV = 24'h000014;
	localparam logic [3:0] RST_LOCK_BW = 4'h7;
	localparam logic [3:0] RST_ACQ_BW = 4'h7;
	localparam logic [2:0] RST_LOCK_DAMP = 3'h3;
	localparam logic [2:0] RST_ACQ_DAMP = 3'h3;
	localparam logic [1:0] RST_GAIN = 2'h1;
	localparam logic RST_QUICK_ACQ = 1'b1;
	localparam logic [7:0] RST_PHASE_WIN = 8'h3F;
	localparam logic [8:0] RST_MOD_INT = 9'h02C;
	localparam logic [20:0] RST_MOD_FRAC = 21'h181949;
	localparam logic [1:0] RST_MOD_ORDER = 2'h3;
	localparam logic [1:0] RST_OSC_GAIN = 2'h0;
	localparam logic [2:0] RST_DITHER = 3'h0;

	// Address falls in the three-byte group starting at base
	function automatic logic dpicf_hit3(input dpicf_addr_t addr, input dpicf_addr_t base);
		return (addr >= base) && (addr < base + 10'h003);
	endfunction

	// Byte index within a group, lowest address first
	function automatic logic [1:0] dpicf_idx(input dpicf_addr_t addr, input dpicf_addr_t base);
		dpicf_addr_t d;
		d = addr - base;
		return d[1:0];
	endfunction

	// Byte of a 24-bit field, most significant at index 0
	function automatic logic [7:0] dpicf_get(input logic [23:0] v, input logic [1:0] idx);
		case (idx)
			2'h0: return v[23:16];
			2'h1: return v[15:8];
			default: return v[7:0];
		endcase
	endfunction

	// Replace one byte of a 24-bit field, most significant at index 0
	function automatic logic [23:0] dpicf_put(input logic [23:0] v, input logic [1:0] idx, input logic [7:0] b);
		logic [23:0] r;
		r = v;
		case (idx)
			2'h0: r[23:16] = b;
			2'h1: r[15:8] = b;
			default: r[7:0] = b;
		endcase
		return r;
	endfunction
endpackage

// File: dpicf_sel_if.sv
// Interface: configuration fields to the loop selector and its decoded choices back
`timescale 1ns/1ps
`default_nettype none
interface dpicf_sel_if;
	logic quick_acquire_enable;
	logic phase_locked;
	logic ref_in_use;
	logic [1:0] state_ctrl;
	logic [3:0] locked_bandwidth;
	logic [3:0] acquire_bandwidth;
	logic [2:0] locked_damping;
	logic [2:0] acquire_damping;
	logic [20:0] clk_ref_predivider;
	logic [20:0] fb_ref_predivider;
	logic [23:0] clk_ref_feedback_divider;
	logic [23:0] fb_ref_feedback_divider;
	logic [3:0] active_bandwidth;
	logic [2:0] active_damping;
	logic force_free_running;
	logic force_normal_track;
	logic [20:0] active_predivider;
	logic [23:0] active_feedback_divider;

	// Register bank side
	modport bank (
		output quick_acquire_enable, phase_locked, ref_in_use, state_ctrl,
		output locked_bandwidth, acquire_bandwidth, locked_damping, acquire_damping,
		output clk_ref_predivider, fb_ref_predivider, clk_ref_feedback_divider, fb_ref_feedback_divider,
		input active_bandwidth, active_damping, force_free_running, force_normal_track,
		input active_predivider, active_feedback_divider
	);
	// Selector side
	modport sel (
		input quick_acquire_enable, phase_locked, ref_in_use, state_ctrl,
		input locked_bandwidth, acquire_bandwidth, locked_damping, acquire_damping,
		input clk_ref_predivider, fb_ref_predivider, clk_ref_feedback_divider, fb_ref_feedback_divider,
		output active_bandwidth, active_damping, force_free_running, force_normal_track,
		output active_predivider, active_feedback_divider
	);
endinterface
`default_nettype wire

// File: dpicf_loop_sel.sv
// Loop selector: picks loop settings and dividers, decodes the state override
`timescale 1ns/1ps
`default_nettype none
module dpicf_loop_sel
	import dpicf_pkg::*;
(
	// Fields in, choices out
	dpicf_sel_if.sel sif
);
	// Purely combinational; the bank registers every result
	always_comb begin
		// Acquire settings only while quick acquire is on and phase lock is missing
		if (sif.quick_acquire_enable && !sif.phase_locked) begin
			sif.active_bandwidth = sif.acquire_bandwidth;
			sif.active_damping = sif.acquire_damping;
		end else begin
			sif.active_bandwidth = sif.locked_bandwidth;
			sif.active_damping = sif.locked_damping;
		end
		// Reference 1 is the feedback input, reference 0 the clock input
		if (sif.ref_in_use) begin
			sif.active_predivider = sif.fb_ref_predivider;
			sif.active_feedback_divider = sif.fb_ref_feedback_divider;
		end else begin
			sif.active_predivider = sif.clk_ref_predivider;
			sif.active_feedback_divider = sif.clk_ref_feedback_divider;
		end
		// Reserved code 11 falls back to automatic running
		sif.force_free_running = (sif.state_ctrl == STATE_FREE_RUNNING_STATE);
		sif.force_normal_track = (sif.state_ctrl == STATE_NORMAL);
	end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the digital PLL input and feedback configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dpicf_pkg::*;
	typedef struct {dpicf_addr_t a; logic [7:0] w; logic [7:0] r;} dpicf_row_s;
	logic clk_sys, srst, ce, reg_wr, reg_rd, phase_locked, ref_in_use;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, phase_window;
	logic reg_rvalid, auto_ref_select, force_free_running, force_normal_track;
	logic [3:0] active_bandwidth;
	logic [2:0] active_damping, dither_gain;
	logic [1:0] loop_filter_gain, modulator_order, oscillator_control_gain;
	logic [20:0] active_predivider;
	logic [23:0] active_feedback_divider;
	logic [29:0] modulator_value;
	int err_count = 0;
	int tests_run = 0;
	// Reset read-back, then write/read-back pairs; last column is the expected read
	dpicf_row_s rst_rows[15] = '{'{10'h008, 8'h00, 8'h17}, '{10'h00A, 8'h00, 8'h00}, '{10'h00B, 8'h00, 8'h00},
		'{10'h00C, 8'h00, 8'h00}, '{10'h00D, 8'h00, 8'h14}, '{10'h011, 8'h00, 8'h00}, '{10'h013, 8'h00, 8'h14},
		'{10'h016, 8'h00, 8'h14}, '{10'h017, 8'h00, 8'h77}, '{10'h018, 8'h00, 8'h6D}, '{10'h023, 8'h00, 8'h01},
		'{10'h024, 8'h00, 8'h3F}, '{10'h026, 8'h00, 8'h2C}, '{10'h028, 8'h00, 8'h18}, '{10'h02A, 8'h00, 8'h49}};
	dpicf_row_s rows[24] = '{'{10'h00B, 8'h1F, 8'h1F}, '{10'h00C, 8'hA5, 8'hA5}, '{10'h00D, 8'h3C, 8'h3C},
		'{10'h00E, 8'h10, 8'h10}, '{10'h00F, 8'h22, 8'h22}, '{10'h010, 8'h33, 8'h33}, '{10'h011, 8'hAB, 8'hAB},
		'{10'h012, 8'hCD, 8'hCD}, '{10'h013, 8'hEF, 8'hEF}, '{10'h014, 8'h12, 8'h12}, '{10'h015, 8'h34, 8'h34},
		'{10'h016, 8'h56, 8'h56}, '{10'h017, 8'h5A, 8'h5A}, '{10'h018, 8'h2E, 8'h2E}, '{10'h023, 8'h00, 8'h00},
		'{10'h024, 8'h01, 8'h01}, '{10'h025, 8'h01, 8'h01}, '{10'h026, 8'hFF, 8'hFF}, '{10'h028, 8'h1F, 8'h1F},
		'{10'h029, 8'h00, 8'h00}, '{10'h02A, 8'h01, 8'h01}, '{10'h02F, 8'hD5, 8'hD5}, '{10'h030, 8'hAA, 8'h00},
		'{10'h01F, 8'h00, 8'hFF}};

	dpicf_regs i_dpicf_regs (.clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.phase_locked(phase_locked), .ref_in_use(ref_in_use), .auto_ref_select(auto_ref_select),
		.force_free_running(force_free_running), .force_normal_track(force_normal_track),
		.active_bandwidth(active_bandwidth), .active_damping(active_damping), .loop_filter_gain(loop_filter_gain),
		.active_predivider(active_predivider), .active_feedback_divider(active_feedback_divider),
		.phase_window(phase_window), .modulator_value(modulator_value), .modulator_order(modulator_order),
		.oscillator_control_gain(oscillator_control_gain), .dither_gain(dither_gain));

	// 10 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic cmp_out(input logic [29:0] got, input logic [29:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_out({22'h0, got}, {22'h0, exp});
	endtask

	// Inputs move a fixed 10 ns after the edge, so the design never samples them mid-change
	task automatic step();
		@(posedge clk_sys);
		#10;
	endtask

	task automatic wr(input dpicf_addr_t a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
		// Idle edge, so the next strobe is never set in the same step it was cleared
		step();
	endtask

	// Answer is fixed at the same edge that takes the read, so no polling is needed
	task automatic rd(input dpicf_addr_t a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		step();
		reg_rd = 1'b0;
		cmp_out({29'h0, reg_rvalid}, 30'h1);
		cmp_byte(reg_rdata, e);
		step();
	endtask

	task automatic check_defaults();
		cmp_out({29'h0, auto_ref_select}, 30'h1);
		cmp_out({28'h0, force_free_running, force_normal_track}, 30'h0);
		cmp_out(30'(active_predivider), 30'h14);
		cmp_out(30'(active_feedback_divider), 30'h14);
		cmp_out(modulator_value, {9'h02C, 21'h181949});
		foreach (rst_rows[i]) rd(rst_rows[i].a, rst_rows[i].r);
	endtask

	// Hang guard
	initial begin
		#2000000;
		err_count++;
		print_verdict();
	end

	initial begin
		srst = 1'b1;
		ce = 1'b1;
		{reg_wr, reg_rd, phase_locked, ref_in_use} = 4'h0;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		repeat (12) @(posedge clk_sys);
		#10;
		srst = 1'b0;
		check_defaults();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].r);
		end
		cmp_out(30'(active_predivider), 30'h1FA53C);
		cmp_out(30'(active_feedback_divider), 30'hABCDEF);
		cmp_out(modulator_value, {9'h1FF, 21'h1F0001});
		cmp_out({23'h0, modulator_order, oscillator_control_gain, dither_gain}, 30'h6D);
		ref_in_use = 1'b1;
		phase_locked = 1'b0;
		step();
		cmp_out(30'(active_predivider), 30'h102233);
		cmp_out(30'(active_feedback_divider), 30'h123456);
		cmp_out({23'h0, active_bandwidth, active_damping}, {23'h0, 4'h5, 3'h1});
		wr(OFS_QUICK_ACQ, 8'h01);
		cmp_out({23'h0, active_bandwidth, active_damping}, {23'h0, 4'hA, 3'h3});
		phase_locked = 1'b1;
		step();
		cmp_out({21'h0, active_bandwidth, active_damping, loop_filter_gain}, {21'h0, 4'h5, 3'h1, 2'h2});
		// Every state code, including the reserved one
		for (int s = 0; s < 4; s++) begin
			wr(OFS_PLL_STATE, 8'(s));
			cmp_out({28'h0, force_free_running, force_normal_track}, 30'(s == 1 ? 2 : (s == 2 ? 1 : 0)));
		end
		wr(OFS_REF_SELECT, 8'h00);
		rd(OFS_REF_SELECT, 8'h17);
		cmp_out({29'h0, auto_ref_select}, 30'h1);
		// Write and read in one cycle: the read returns the old window
		reg_addr = OFS_PHASE_WIN;
		reg_wdata = 8'h80;
		{reg_wr, reg_rd} = 2'b11;
		step();
		{reg_wr, reg_rd} = 2'b00;
		cmp_byte(reg_rdata, 8'h01);
		cmp_byte(phase_window, 8'h80);
		step();
		// Strobes while the clock enable is low are lost
		ce = 1'b0;
		wr(OFS_PHASE_WIN, 8'h77);
		ce = 1'b1;
		rd(OFS_PHASE_WIN, 8'h80);
		// Reset in mid-run brings every field back
		srst = 1'b1;
		step();
		srst = 1'b0;
		phase_locked = 1'b0;
		ref_in_use = 1'b0;
		step();
		check_defaults();
		print_verdict();
	end
endmodule
`default_nettype wire
